// ===== hdl/axis_cmd_cfg.svh
// Purpose: constants for the axis zero-set and accel-update command block
// Assumes: one axis, register port with one-cycle read latency
// Notes: offsets are word indices on the plain register port
`ifndef AXIS_CMD_CFG_SVH
`define AXIS_CMD_CFG_SVH
`define CMD_IDLE 16'h0000
`define CMD_ORIGIN_SET 16'h0009
`define CMD_ACCEL_UPDATE 16'h000A
`define ADDR_CMD 4'h0
`define ADDR_CTRL 4'h1
`define ADDR_OFFSET 4'h2
`define ADDR_ACCEL 4'h3
`define ADDR_RESP 4'h4
`define ADDR_STATUS 4'h5
`define ADDR_WARN 4'h6
`define ADDR_ALARM 4'h7
`define ADDR_POS 4'h8
`define CTRL_PAUSE_BIT 0
`define CTRL_ABORT_BIT 1
`define ST_EXEC_BIT 0
`define ST_HOLD_BIT 1
`define ST_ERR_BIT 2
`define ST_DONE_BIT 3
`define ST_ORIGIN_BIT 4
`define ST_DIST_BIT 5
`define ST_LIMIT_BIT 6
`define ACCEL_TIMEOUT 8'hC8
`endif

// ===== hdl/axis_cmd_pkg.sv
// Purpose: types for the axis command block
// Assumes: nothing
// Notes: one-hot state codes
package axis_cmd_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_ORIGIN = 4'h2,
        ST_ACCEL = 4'h4,
        ST_FINISH = 4'h8
    } cmd_state_t;
endpackage

// ===== hdl/axis_cmd_unit.sv
// Purpose: per-axis handler for the origin-set and accel-update commands
// Assumes: drive parameter link answers with ack or fail pulses
// Notes: software writes the command word, reads response and status
// Functional notes
// RULE_01 - code 9 starts origin set
// RULE_02 - pause and abort bits ignored
// RULE_03 - apply origin offset after new zero
// RULE_04 - response 9 during origin set
// RULE_05 - executing bit during origin set
// RULE_06 - hold done stays low, origin set
// RULE_07 - error end sticky until new command
// RULE_08 - done bit after origin set
// RULE_09 - origin established bit when finished
// RULE_10 - host checks alarms and idle first
// RULE_11 - code 10 starts accel update
// RULE_12 - send accel time to drive constant
// RULE_13 - response 10 during accel update
// RULE_14 - executing bit during accel update
// RULE_15 - host writes 0 to finish
// RULE_16 - hold done stays low, accel update
// RULE_17 - accel error end until new command
// RULE_18 - done bit after accel update
// RULE_19 - keep latest warning and alarm
// RULE_20 - present position becomes origin
// RULE_21 - soft limits only after origin set
// RULE_22 - idle reports 0, not executing
`timescale 1ns/10ps
`include "axis_cmd_cfg.svh"
module axis_cmd_unit (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    input wire logic [31:0] presentPosition,
    input wire logic distributionDone,
    input wire logic [31:0] warningIn,
    input wire logic warningValid,
    input wire logic [31:0] alarmIn,
    input wire logic alarmValid,
    output logic paramWrReq,
    output logic [31:0] paramWrData,
    input wire logic paramAck,
    input wire logic paramFail,
    output logic softLimitEnable
);
    axis_cmd_pkg::cmd_state_t state; // command sequencer
    axis_cmd_pkg::cmd_state_t next_state; // combinational next
    logic [15:0] commandWord; // command code word
    logic [1:0] ctrlBits; // pause/abort, stored only
    logic [31:0] originOffsetValue; // offset applied at zero set
    logic [31:0] linearAccelTime; // accel time setting
    logic [31:0] machinePosition; // machine coordinate position
    logic [31:0] zeroBase; // raw position that is the new origin
    logic [15:0] responseCode; // command response word
    logic executing; // command executing flag
    logic errorEnd; // error end flag
    logic execDone; // execution done flag
    logic originDone; // origin established flag
    logic [31:0] latestWarning; // most recent warning
    logic [31:0] latestAlarm; // most recent alarm
    logic [7:0] waitCount; // drive answer timeout
    logic cmdWrite; // host writes command word
    logic newCmd; // write of a different command code

    // a rewrite of the same code is not a new command and keeps the flags
    assign cmdWrite = regWr && (regAddr == `ADDR_CMD);
    assign newCmd = cmdWrite && (regWdata[15:0] != commandWord);

    // register writes from the host
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            commandWord <= `CMD_IDLE;
            ctrlBits <= 2'h0;
            originOffsetValue <= 32'h00000000;
            linearAccelTime <= 32'h00000000;
        end else if (regWr) begin
            unique case (regAddr)
                `ADDR_CMD: commandWord <= regWdata[15:0];
                // held for readback; the sequencer never looks at them
                `ADDR_CTRL: ctrlBits <= regWdata[1:0]; // see RULE_02
                `ADDR_OFFSET: originOffsetValue <= regWdata;
                `ADDR_ACCEL: linearAccelTime <= regWdata;
                default: begin
                end
            endcase
        end
    end

    // next state from command word and drive answers
    always_comb begin
        next_state = state;
        unique case (state)
            axis_cmd_pkg::ST_IDLE: begin
                if (commandWord == `CMD_ORIGIN_SET) begin
                    next_state = axis_cmd_pkg::ST_ORIGIN; // see RULE_01
                end else if (commandWord == `CMD_ACCEL_UPDATE) begin
                    next_state = axis_cmd_pkg::ST_ACCEL; // see RULE_11
                end
            end
            // origin set is a single-cycle latch of the position
            axis_cmd_pkg::ST_ORIGIN: next_state = axis_cmd_pkg::ST_FINISH;
            axis_cmd_pkg::ST_ACCEL: begin
                if (paramAck || paramFail || waitCount == 8'h00) begin
                    next_state = axis_cmd_pkg::ST_FINISH;
                end
            end
            // stay until the host selects idle
            axis_cmd_pkg::ST_FINISH: begin
                if (commandWord == `CMD_IDLE) begin
                    next_state = axis_cmd_pkg::ST_IDLE; // see RULE_15
                end
            end
            default: next_state = axis_cmd_pkg::ST_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            state <= axis_cmd_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // drive answer timeout; a silent drive counts as a fault
    // the count is long next to a normal answer, so only a dead drive trips it
    always_ff @(posedge core_clk) begin
        if (!nrst || state != axis_cmd_pkg::ST_ACCEL) begin
            waitCount <= `ACCEL_TIMEOUT;
        end else if (waitCount != 8'h00) begin
            waitCount <= waitCount - 8'h01;
        end
    end

    // parameter transfer to the drive's second-step accel constant
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            paramWrReq <= 1'b0;
            paramWrData <= 32'h00000000;
        end else begin
            // request holds until the drive answers or the timeout count runs out
            paramWrReq <= (next_state == axis_cmd_pkg::ST_ACCEL); // see RULE_12
            // frozen once running, so a late host write cannot change it
            if (state == axis_cmd_pkg::ST_IDLE) begin
                paramWrData <= linearAccelTime; // see RULE_12
            end
        end
    end

    // response code and executing flag follow the state
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            responseCode <= `CMD_IDLE;
            executing <= 1'b0;
        end else begin
            unique case (next_state)
                axis_cmd_pkg::ST_ORIGIN: begin
                    responseCode <= `CMD_ORIGIN_SET; // see RULE_04
                    executing <= 1'b1; // see RULE_05
                end
                axis_cmd_pkg::ST_ACCEL: begin
                    responseCode <= `CMD_ACCEL_UPDATE; // see RULE_13
                    executing <= 1'b1; // see RULE_14
                end
                axis_cmd_pkg::ST_FINISH: begin
                    // response code stays until the host selects idle
                    executing <= 1'b0; // see RULE_05
                end
                default: begin
                    responseCode <= `CMD_IDLE; // see RULE_22
                    executing <= 1'b0; // see RULE_22
                end
            endcase
        end
    end

    // done and error flags; a new command code clears both
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            execDone <= 1'b0;
            errorEnd <= 1'b0;
        end else begin
            if (newCmd) begin
                execDone <= 1'b0;
                errorEnd <= 1'b0; // see RULE_07
            end
            if (state == axis_cmd_pkg::ST_ORIGIN) begin
                execDone <= 1'b1; // see RULE_08
            end
            if (state == axis_cmd_pkg::ST_ACCEL && next_state == axis_cmd_pkg::ST_FINISH) begin
                execDone <= 1'b1; // see RULE_18
                // set wins over a clear in the same cycle
                if (paramFail || !paramAck) begin
                    errorEnd <= 1'b1; // see RULE_17
                end
            end
        end
    end

    // origin capture: no motion, current position becomes the offset value
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            zeroBase <= 32'h00000000;
            originDone <= 1'b0;
        end else if (state == axis_cmd_pkg::ST_ORIGIN) begin
            // offset means origin reads back as the offset value
            zeroBase <= presentPosition - originOffsetValue; // see RULE_20
            originDone <= 1'b1; // see RULE_09
        end
    end

    // machine coordinate, registered for readback
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            machinePosition <= 32'h00000000;
        end else begin
            machinePosition <= presentPosition - zeroBase; // see RULE_03
        end
    end

    // limits stay off until an origin exists; only reset clears it
    assign softLimitEnable = originDone; // see RULE_21

    // latest warning and alarm monitors
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            latestWarning <= 32'h00000000;
            latestAlarm <= 32'h00000000;
        end else begin
            if (warningValid) begin
                latestWarning <= warningIn; // see RULE_19
            end
            if (alarmValid) begin
                latestAlarm <= alarmIn; // see RULE_19
            end
        end
    end

    // read data, one cycle after the strobe, zero otherwise
    always_ff @(posedge core_clk) begin
        if (!nrst || !regRd) begin
            regRdata <= 32'h00000000;
        end else begin
            unique case (regAddr)
                `ADDR_CMD: regRdata <= {16'h0000, commandWord};
                `ADDR_CTRL: regRdata <= {30'h0, ctrlBits};
                `ADDR_OFFSET: regRdata <= originOffsetValue;
                `ADDR_ACCEL: regRdata <= linearAccelTime;
                `ADDR_RESP: regRdata <= {16'h0000, responseCode};
                `ADDR_STATUS: begin
                    // status word gathers the loose flags
                    regRdata <= 32'h00000000;
                    regRdata[`ST_EXEC_BIT] <= executing;
                    // hold done has no source here: never set
                    regRdata[`ST_HOLD_BIT] <= 1'b0; // see RULE_06, RULE_16
                    regRdata[`ST_ERR_BIT] <= errorEnd;
                    regRdata[`ST_DONE_BIT] <= execDone;
                    regRdata[`ST_ORIGIN_BIT] <= originDone;
                    regRdata[`ST_DIST_BIT] <= distributionDone;
                    regRdata[`ST_LIMIT_BIT] <= originDone;
                end
                `ADDR_WARN: regRdata <= latestWarning;
                `ADDR_ALARM: regRdata <= latestAlarm;
                `ADDR_POS: regRdata <= machinePosition;
                default: regRdata <= 32'h00000000;
            endcase
        end
    end

    // checks
    // response and executing flag in the origin cycle
    a_origin_response: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE_04
        state == axis_cmd_pkg::ST_ORIGIN |-> responseCode == `CMD_ORIGIN_SET && executing)
        else $error("origin set response wrong");
    // response and executing flag while updating
    a_accel_response: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE_13
        state == axis_cmd_pkg::ST_ACCEL |-> responseCode == `CMD_ACCEL_UPDATE && executing)
        else $error("accel response wrong");
    // origin set starts the cycle after code 9 is seen
    a_origin_start: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE_01
        state == axis_cmd_pkg::ST_IDLE && commandWord == `CMD_ORIGIN_SET
        |=> state == axis_cmd_pkg::ST_ORIGIN)
        else $error("origin set not started");
    // update starts and asks the drive
    a_accel_start: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE_11
        state == axis_cmd_pkg::ST_IDLE && commandWord == `CMD_ACCEL_UPDATE
        |=> state == axis_cmd_pkg::ST_ACCEL ##1 paramWrReq)
        else $error("accel update not started");
    // completion flags right after the origin cycle
    a_origin_done: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE_09
        state == axis_cmd_pkg::ST_ORIGIN |=> originDone && execDone && !executing)
        else $error("origin completion flags wrong");
    // an accepted write ends the update with done set and executing low
    a_accel_finish: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE_18
        state == axis_cmd_pkg::ST_ACCEL && paramAck |=> execDone && !executing)
        else $error("accel completion flags wrong");
    // a refused write ends in error
    a_accel_error: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE_17
        state == axis_cmd_pkg::ST_ACCEL && paramFail |=> errorEnd)
        else $error("accel fault not flagged");
    // idle settles to response 0, not executing
    a_idle_quiet: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE_22
        state == axis_cmd_pkg::ST_IDLE && $past(state) == axis_cmd_pkg::ST_IDLE
        |-> responseCode == `CMD_IDLE && !executing)
        else $error("idle not quiet");
    // soft limits switch on only out of an origin set
    a_limit_gate: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE_21
        $rose(softLimitEnable) |-> $past(state) == axis_cmd_pkg::ST_ORIGIN)
        else $error("soft limit enabled early");
    // pause and abort requests never hold an origin set
    a_origin_runs: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE_02
        state == axis_cmd_pkg::ST_ORIGIN && ctrlBits != 2'h0
        |=> state == axis_cmd_pkg::ST_FINISH)
        else $error("origin set held by control bits");
    // executing is low once a command has finished
    a_finish_quiet: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE_14
        state == axis_cmd_pkg::ST_FINISH |-> !executing)
        else $error("executing high after finish");
    // error end holds until a different code is written
    a_error_sticky: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE_07
        errorEnd && !newCmd |=> errorEnd)
        else $error("error end dropped early");
    // done holds until a different code is written
    a_done_sticky: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE_18
        execDone && !newCmd |=> execDone)
        else $error("done dropped early");
    // a drive that never answers ends the update as a fault
    a_timeout_fault: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE_17
        state == axis_cmd_pkg::ST_ACCEL && waitCount == 8'h00 && !paramAck
        |=> errorEnd && execDone)
        else $error("timeout not flagged");
    // two cycles on, the position reads the offset plus motion since the origin
    a_origin_zero: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE_20
        state == axis_cmd_pkg::ST_ORIGIN |=> ##1 machinePosition == $past(presentPosition)
        - $past(presentPosition, 2) + $past(originOffsetValue, 2))
        else $error("machine position not rebased");
    // request and its data stand until the drive answers or time runs out
    a_param_hold: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE_12
        state == axis_cmd_pkg::ST_ACCEL && !paramAck && !paramFail && waitCount != 8'h00
        |=> paramWrReq && $stable(paramWrData))
        else $error("drive request dropped early");
    // a finished command keeps its response code until idle is selected
    a_resp_hold: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE_15
        state == axis_cmd_pkg::ST_FINISH && commandWord != `CMD_IDLE
        |=> $stable(responseCode))
        else $error("response changed before idle");
endmodule

// ===== bench/drive_param_model.sv
// Purpose: behavioural servo drive answering accel constant writes
// Assumes: request is a level held until ack or fail is seen
// Notes: mode 0 accepts, 1 refuses, 2 stays silent to force a timeout
`timescale 1ns/10ps
module drive_param_model (
    input wire logic core_clk,
    input wire logic paramWrReq,
    input wire logic [31:0] paramWrData,
    input wire logic [1:0] mode,
    input wire logic [7:0] delay,
    output logic paramAck,
    output logic paramFail,
    output logic [31:0] lastData
);
    // one answer per request; waits for the request to drop so it never answers twice
    initial begin
        paramAck = 1'b0;
        paramFail = 1'b0;
        lastData = 32'h00000000;
        forever begin
            @(posedge core_clk);
            #1;
            if (paramWrReq) begin
                lastData = paramWrData; // constant stored in the drive
                repeat (delay) @(posedge core_clk);
                #1;
                paramAck = (mode == 2'h0);
                paramFail = (mode == 2'h1);
                @(posedge core_clk);
                #1;
                paramAck = 1'b0;
                paramFail = 1'b0;
                while (paramWrReq) begin
                    @(posedge core_clk);
                    #1;
                end
            end
        end
    end
endmodule

// ===== bench/axis_cmd_unit_tb.sv
// Purpose: self-checking bench for the axis command block
// Assumes: register port with one-cycle read data, drive model on the far side
// Notes: timeout of 200 cycles is the designer's choice
`timescale 1ns/10ps
`include "axis_cmd_cfg.svh"
`define CHK(nm, ex, gt) begin cmpCount++; if ((gt) !== (ex)) begin errors++; \
    $display("MISMATCH %s exp %h got %h", nm, ex, gt); end end
module axis_cmd_unit_tb;
    logic core_clk, nrst, regWr, regRd, warningValid, alarmValid, distributionDone;
    logic [3:0] regAddr;
    logic [31:0] regWdata, regRdata, presentPosition, warningIn, alarmIn, paramWrData, lastData;
    logic paramWrReq, paramAck, paramFail, softLimitEnable;
    logic [1:0] mode; // drive answer kind
    logic [7:0] delay; // drive answer latency
    logic [31:0] rdv; // last read value
    int errors = 0;
    int cmpCount = 0;
    int cycles = 0;
    axis_cmd_unit uut (.core_clk(core_clk), .nrst(nrst), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .presentPosition(presentPosition), .distributionDone(distributionDone),
        .warningIn(warningIn), .warningValid(warningValid), .alarmIn(alarmIn),
        .alarmValid(alarmValid), .paramWrReq(paramWrReq), .paramWrData(paramWrData),
        .paramAck(paramAck), .paramFail(paramFail), .softLimitEnable(softLimitEnable));
    drive_param_model drive (.core_clk(core_clk), .paramWrReq(paramWrReq),
        .paramWrData(paramWrData), .mode(mode), .delay(delay), .paramAck(paramAck),
        .paramFail(paramFail), .lastData(lastData));
    // 100 ns clock
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    // hang guard: far above the longest scenario
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 6000) begin
            errors++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmpCount, errors);
        if (errors == 0 && cmpCount > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // one-cycle write strobe
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        regWr <= 1'b1; regAddr <= a; regWdata <= d;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask
    // one-cycle read strobe, data taken in the following cycle only
    task automatic rd(input logic [3:0] a);
        @(posedge core_clk);
        regRd <= 1'b1; regAddr <= a;
        @(posedge core_clk);
        regRd <= 1'b0;
        #1 rdv = regRdata;
    endtask
    // status check; hold-done must always read low
    task automatic chkSt(input logic ex, input logic er, input logic dn);
        rd(`ADDR_STATUS);
        `CHK("exec", ex, rdv[`ST_EXEC_BIT])
        `CHK("error", er, rdv[`ST_ERR_BIT])
        `CHK("done", dn, rdv[`ST_DONE_BIT])
        `CHK("hold", 1'b0, rdv[`ST_HOLD_BIT])
    endtask
    // bounded poll until the executing bit drops
    task automatic waitIdle();
        for (int i = 0; i < 300; i++) begin
            rd(`ADDR_STATUS);
            if (rdv[`ST_EXEC_BIT] === 1'b0) break;
        end
    endtask
    task automatic tOrigin();
        rd(`ADDR_STATUS);
        `CHK("origin before", 1'b0, rdv[`ST_ORIGIN_BIT])
        `CHK("limit before", 1'b0, softLimitEnable)
        @(posedge core_clk);
        presentPosition <= 32'h00001000;
        wr(`ADDR_OFFSET, 32'h00000500);
        wr(`ADDR_CTRL, 32'h00000003); // pause and abort both requested
        rd(`ADDR_CTRL);
        `CHK("ctrl kept", 32'h00000003, rdv)
        wr(`ADDR_CMD, {16'h0000, `CMD_ORIGIN_SET});
        rd(`ADDR_RESP);
        `CHK("resp origin", 32'h00000009, rdv)
        waitIdle();
        chkSt(1'b0, 1'b0, 1'b1);
        `CHK("origin bit", 1'b1, rdv[`ST_ORIGIN_BIT])
        `CHK("limit on", 1'b1, softLimitEnable)
        `CHK("limit bit", 1'b1, rdv[`ST_LIMIT_BIT])
        @(posedge core_clk);
        presentPosition <= 32'h00001010;
        rd(`ADDR_POS);
        rd(`ADDR_POS);
        `CHK("machine pos", 32'h00000510, rdv)
        wr(`ADDR_CTRL, 32'h00000000);
        wr(`ADDR_CMD, 32'h00000000);
        rd(`ADDR_RESP);
        `CHK("resp idle", 32'h00000000, rdv)
        chkSt(1'b0, 1'b0, 1'b0);
        $display("test origin done");
    endtask
    // accel update with a given drive answer; silent drive means timeout
    task automatic tAccel(input logic [1:0] m, input logic [31:0] t, input logic er);
        mode <= m; delay <= 8'h06;
        wr(`ADDR_ACCEL, t);
        // host side checks before it may issue the update
        rd(`ADDR_RESP);
        `CHK("pre resp", 32'h00000000, rdv)
        rd(`ADDR_WARN);
        `CHK("pre warning", 32'h00000000, rdv)
        rd(`ADDR_ALARM);
        `CHK("pre alarm", 32'h00000000, rdv)
        rd(`ADDR_STATUS);
        `CHK("pre exec", 1'b0, rdv[`ST_EXEC_BIT])
        `CHK("pre dist", 1'b1, rdv[`ST_DIST_BIT])
        wr(`ADDR_CMD, {16'h0000, `CMD_ACCEL_UPDATE});
        wr(`ADDR_CTRL, 32'h00000003); // requests mid-run must not stop it
        rd(`ADDR_RESP);
        `CHK("resp accel", 32'h0000000A, rdv)
        chkSt(1'b1, 1'b0, 1'b0);
        waitIdle();
        chkSt(1'b0, er, 1'b1);
        chkSt(1'b0, er, 1'b1);
        `CHK("drive const", t, lastData)
        wr(`ADDR_CTRL, 32'h00000000);
        wr(`ADDR_CMD, 32'h00000000);
        chkSt(1'b0, 1'b0, 1'b0);
        rd(`ADDR_RESP);
        `CHK("resp idle", 32'h00000000, rdv)
        $display("test accel mode %0d done", m);
    endtask
    task automatic tMonitor();
        @(posedge core_clk);
        warningValid <= 1'b1; warningIn <= 32'h00000011;
        alarmValid <= 1'b1; alarmIn <= 32'h00000021;
        distributionDone <= 1'b0;
        @(posedge core_clk);
        warningIn <= 32'h00000012; alarmIn <= 32'h00000022;
        @(posedge core_clk);
        warningValid <= 1'b0; alarmValid <= 1'b0; alarmIn <= 32'h0000FFFF;
        rd(`ADDR_WARN);
        `CHK("warning", 32'h00000012, rdv)
        rd(`ADDR_ALARM);
        `CHK("alarm", 32'h00000022, rdv)
        rd(4'hF);
        `CHK("unmapped", 32'h00000000, rdv)
        rd(`ADDR_STATUS);
        `CHK("dist low", 1'b0, rdv[`ST_DIST_BIT])
        $display("test monitor done");
    endtask
    initial begin
        nrst = 1'b0; regWr = 1'b0; regRd = 1'b0; regAddr = 4'h0; regWdata = 32'h00000000;
        presentPosition = 32'h00000000; distributionDone = 1'b1;
        warningIn = 32'h00000000; warningValid = 1'b0;
        alarmIn = 32'h00000000; alarmValid = 1'b0; mode = 2'h0; delay = 8'h06;
        repeat (5) @(posedge core_clk);
        nrst <= 1'b1;
        tOrigin();
        tAccel(2'h0, 32'h00000123, 1'b0);
        tAccel(2'h1, 32'h00000456, 1'b1);
        tAccel(2'h2, 32'h00000789, 1'b1);
        tMonitor();
        give_verdict();
    end
endmodule
